// File: shared/sep_pkg.sv
// Constants and types shared by the serial nonvolatile memory command core.
package sep_pkg;

   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned T_WC_NS       = 5000000;
   localparam int unsigned T_WC_CYC      = T_WC_NS / CLK_PERIOD_NS;

   localparam int unsigned ADDR_W_16K    = 14;
   localparam int unsigned ADDR_W_MIN    = 8;
   localparam int unsigned ADDR_W_MAX    = 16;
   localparam int unsigned PAGE_BYTES    = 64;
   localparam int unsigned PAGE_AW       = 6;
   localparam int unsigned FIFO_DEPTH    = 2;

   localparam logic [3:0] CMD_UPPER      = 4'h0;
   localparam logic [2:0] cmd_set_write_enable   = 3'h6;
   localparam logic [2:0] cmd_clear_write_enable = 3'h4;
   localparam logic [2:0] cmd_read_status        = 3'h5;
   localparam logic [2:0] cmd_write_status       = 3'h1;
   localparam logic [2:0] CMD_READ_ARRAY         = 3'h3;
   localparam logic [2:0] CMD_WRITE_ARRAY        = 3'h2;

   localparam logic [7:0] STATUS_BUSY_ALL = 8'hff;
   localparam logic [7:0] IDLE_BYTE       = 8'hff;
   localparam logic [1:0] BP_RESET        = 2'h0;
   localparam logic       HPE_RESET       = 1'b0;
   localparam logic [1:0] BP_NONE         = 2'h0;
   localparam logic [1:0] BP_QUARTER      = 2'h1;
   localparam logic [1:0] BP_HALF         = 2'h2;
   localparam logic [1:0] QUARTER_TOP     = 2'h3;

   // Bit layout of the status byte as shifted out.
   typedef struct packed {
      logic       hw_protect_enable_bit;
      logic [2:0] unused;
      logic       block_protect_high_bit;
      logic       block_protect_low_bit;
      logic       write_enable_latch;
      logic       busy;
   } sep_status_type;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
      logic wp_n;
   } sep_pins_type;

endpackage

// File: rtl/sep_core.sv
// Command core of a serial byte-wide nonvolatile memory on an SPI mode 0 link.
module sep_core
#(
   parameter int unsigned ADDR_W    = sep_pkg::ADDR_W_16K,
   parameter int unsigned WC_CYCLES = sep_pkg::T_WC_CYC
)
(
   input  wire logic                   core_clk,
   input  wire logic                   rst_n,
   input  wire logic                   cs_n,
   input  wire logic                   sck,
   input  wire logic                   si,
   input  wire logic                   wp_n,
   output logic                        so,
   output logic                        so_oe,
   output sep_pkg::sep_status_type     stat_o
);

   if (ADDR_W < sep_pkg::ADDR_W_MIN || ADDR_W > sep_pkg::ADDR_W_MAX || WC_CYCLES < 2)
   begin : g_bad_param
      $error("sep_core: unsupported ADDR_W or WC_CYCLES");
   end

   localparam int unsigned WCW = $clog2(WC_CYCLES + 1);
   localparam int unsigned PGW = ADDR_W - sep_pkg::PAGE_AW;

   typedef enum logic [2:0] {
      ST_CMD, ST_ADDR_HI, ST_ADDR_LO, ST_RDATA, ST_WDATA, ST_RSTAT, ST_WSTAT, ST_IGNORE
   } sep_state_type;

   function automatic logic prot_f(input logic [1:0] bp, input logic [ADDR_W-1:0] a);
      logic p;
      p = 1'b1;
      unique case (bp)
         sep_pkg::BP_NONE:    p = 1'b0;
         sep_pkg::BP_QUARTER: p = (a[ADDR_W-1 -: 2] == sep_pkg::QUARTER_TOP);
         sep_pkg::BP_HALF:    p = a[ADDR_W-1];
         default:             p = 1'b1;
      endcase
      return p;
   endfunction

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   sep_pkg::sep_pins_type pin_raw;
   sep_pkg::sep_pins_type sync1_q;
   sep_pkg::sep_pins_type sync2_q;
   logic                  sck_prev_q;
   logic                  cs_prev_q;

   assign pin_raw = '{cs_n: cs_n, sck: sck, si: si, wp_n: wp_n};

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync1_q    <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
         sync2_q    <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0, wp_n: 1'b1};
         sck_prev_q <= 1'b0;
         cs_prev_q  <= 1'b1;
      end
      else
      begin
         sync1_q    <= pin_raw;
         sync2_q    <= sync1_q;
         sck_prev_q <= sync2_q.sck;
         cs_prev_q  <= sync2_q.cs_n;
      end
   end

   logic selected;
   logic sck_rise;
   logic sck_fall;
   logic cs_rise;
   logic hw_prot;

   assign selected = !sync2_q.cs_n;
   assign sck_rise = sync2_q.sck && !sck_prev_q;
   assign sck_fall = !sync2_q.sck && sck_prev_q;
   assign cs_rise  = sync2_q.cs_n && !cs_prev_q;

   // -----------------------------------------------------------------
   // Input shifter
   // -----------------------------------------------------------------
   logic [6:0] rx_q;
   logic [2:0] bit_cnt_q;
   logic       byte_done;
   logic [7:0] rx_byte;

   assign rx_byte   = {rx_q, sync2_q.si};
   assign byte_done = selected && sck_rise && (bit_cnt_q == 3'h7);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_q      <= 7'h00;
         bit_cnt_q <= 3'h0;
      end
      else if (!selected)
      begin
         bit_cnt_q <= 3'h0;
      end
      else if (sck_rise)
      begin
         rx_q      <= rx_byte[6:0];
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end

   // -----------------------------------------------------------------
   // Command sequencer
   // -----------------------------------------------------------------
   sep_state_type             state_q;
   logic                      busy_q;
   logic                      is_wr_q;
   logic [7:0]                addr_hi_q;
   logic [PGW-1:0]            page_q;
   logic [sep_pkg::PAGE_AW-1:0] wlow_q;
   logic                      data_seen_q;
   logic                      wstat_pend_q;
   logic [7:0]                wstat_byte_q;
   logic [ADDR_W-1:0]         full_addr;
   logic                      start_wr;

   // two address bytes, low bits used
   assign full_addr = ADDR_W'({addr_hi_q, rx_byte});
   assign start_wr  = byte_done && (state_q == ST_ADDR_LO) && is_wr_q;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q      <= ST_CMD;
         is_wr_q      <= 1'b0;
         addr_hi_q    <= 8'h00;
         page_q       <= '0;
         wlow_q       <= '0;
         data_seen_q  <= 1'b0;
         wstat_pend_q <= 1'b0;
         wstat_byte_q <= 8'h00;
      end
      else if (!selected)
      begin
         state_q      <= ST_CMD;
         data_seen_q  <= 1'b0;
         wstat_pend_q <= 1'b0;
      end
      else if (byte_done)
      begin
         unique case (state_q)
            ST_CMD:
            begin
               state_q <= ST_IGNORE;
               if (rx_byte[7:4] == sep_pkg::CMD_UPPER && !(busy_q &&
                   rx_byte[2:0] != sep_pkg::cmd_read_status))
               begin
                  unique case (rx_byte[2:0])
                     sep_pkg::cmd_read_status:  state_q <= ST_RSTAT;
                     sep_pkg::cmd_write_status: state_q <= ST_WSTAT;
                     sep_pkg::CMD_READ_ARRAY:
                     begin
                        state_q <= ST_ADDR_HI;
                        is_wr_q <= 1'b0;
                     end
                     sep_pkg::CMD_WRITE_ARRAY:
                     begin
                        state_q <= ST_ADDR_HI;
                        is_wr_q <= 1'b1;
                     end
                     default:                   state_q <= ST_IGNORE;
                  endcase
               end
            end
            ST_ADDR_HI:
            begin
               addr_hi_q <= rx_byte;
               state_q   <= ST_ADDR_LO;
            end
            ST_ADDR_LO:
            begin
               state_q <= is_wr_q ? ST_WDATA : ST_RDATA;
               page_q  <= full_addr[ADDR_W-1:sep_pkg::PAGE_AW];
               wlow_q  <= full_addr[sep_pkg::PAGE_AW-1:0];
            end
            ST_WDATA:
            begin
               wlow_q      <= wlow_q + 1'b1;
               data_seen_q <= 1'b1;
            end
            ST_WSTAT:
            begin
               wstat_byte_q <= rx_byte;
               wstat_pend_q <= 1'b1;
               state_q      <= ST_IGNORE;
            end
            ST_RDATA, ST_RSTAT, ST_IGNORE: state_q <= state_q;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Status cells and self-timed programming
   // -----------------------------------------------------------------
   logic            wel_q;
   logic [1:0]      bp_q;
   logic            hpe_q;
   logic            kind_array_q;
   logic [WCW-1:0]  wc_cnt_q;
   logic            wc_last;
   logic            cmd_ok;
   logic            go_array;
   logic            go_status;

   assign hw_prot   = !sync2_q.wp_n && hpe_q;
   assign wc_last   = (wc_cnt_q == WCW'(WC_CYCLES - 1));
   assign cmd_ok    = byte_done && (state_q == ST_CMD) && (rx_byte[7:4] == sep_pkg::CMD_UPPER);
   assign go_array  = cs_rise && state_q == ST_WDATA && bit_cnt_q == 3'h0 && data_seen_q &&
                      wel_q;
   assign go_status = cs_rise && wstat_pend_q && bit_cnt_q == 3'h0 && wel_q && !hw_prot;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wel_q        <= 1'b0;
         bp_q         <= sep_pkg::BP_RESET;
         hpe_q        <= sep_pkg::HPE_RESET;
         busy_q       <= 1'b0;
         kind_array_q <= 1'b0;
         wc_cnt_q     <= '0;
      end
      else if (busy_q)
      begin
         wc_cnt_q <= wc_cnt_q + 1'b1;
         if (wc_last)
         begin
            busy_q <= 1'b0;
            wel_q  <= 1'b0;
            if (!kind_array_q)
            begin
               hpe_q <= wstat_byte_q[7];
               bp_q  <= wstat_byte_q[3:2];
            end
         end
      end
      else if (go_array || go_status)
      begin
         busy_q       <= 1'b1;
         kind_array_q <= go_array;
         wc_cnt_q     <= '0;
      end
      else if (cmd_ok && rx_byte[2:0] == sep_pkg::cmd_set_write_enable)
      begin
         wel_q <= 1'b1;
      end
      else if (cmd_ok && rx_byte[2:0] == sep_pkg::cmd_clear_write_enable)
      begin
         wel_q <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Page buffer and array storage
   // -----------------------------------------------------------------
   logic [7:0]                   pg_buf_q [sep_pkg::PAGE_BYTES];
   logic [sep_pkg::PAGE_BYTES-1:0] pg_valid_q;
   logic [7:0]                   mem_q [2**ADDR_W];
   logic                         commit_array;

   assign commit_array = busy_q && wc_last && kind_array_q;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         pg_valid_q <= '0;
      else if (start_wr)
         pg_valid_q <= '0;
      else if (byte_done && state_q == ST_WDATA)
         pg_valid_q[wlow_q] <= 1'b1;
   end

   // Array contents carry no reset: they model retained cells.
   always_ff @(posedge core_clk)
   begin
      if (byte_done && state_q == ST_WDATA)
         pg_buf_q[wlow_q] <= rx_byte;
      if (commit_array)
      begin
         for (int i = 0; i < sep_pkg::PAGE_BYTES; i++)
         begin
            if (pg_valid_q[i] && !prot_f(bp_q, {page_q, sep_pkg::PAGE_AW'(i)}))
               mem_q[{page_q, sep_pkg::PAGE_AW'(i)}] <= pg_buf_q[i];
         end
      end
   end

   // -----------------------------------------------------------------
   // Read prefetch and two-entry buffer
   // -----------------------------------------------------------------
   logic [ADDR_W-1:0] rd_addr_q;
   logic [7:0]        fifo_q [sep_pkg::FIFO_DEPTH];
   logic              fifo_wp_q;
   logic              fifo_rp_q;
   logic [1:0]        fifo_cnt_q;
   logic              in_valid;
   logic              in_ready;
   logic              out_valid;
   logic              out_ready;
   logic              push;
   logic              pop;
   logic [2:0]        out_cnt_q;

   assign in_valid  = selected && state_q == ST_RDATA;
   assign in_ready  = fifo_cnt_q != 2'(sep_pkg::FIFO_DEPTH);
   assign out_valid = fifo_cnt_q != 2'h0;
   assign out_ready = selected && sck_fall && state_q == ST_RDATA && out_cnt_q == 3'h0;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         rd_addr_q <= '0;
      else if (byte_done && state_q == ST_ADDR_LO && !is_wr_q)
         rd_addr_q <= full_addr;
      else if (push)
         rd_addr_q <= rd_addr_q + 1'b1;
   end

   // A receiver stall simply leaves the buffer full, which halts prefetch.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fifo_wp_q  <= 1'b0;
         fifo_rp_q  <= 1'b0;
         fifo_cnt_q <= 2'h0;
         fifo_q     <= '{default: 8'h00};
      end
      else if (state_q != ST_RDATA)
      begin
         fifo_wp_q  <= 1'b0;
         fifo_rp_q  <= 1'b0;
         fifo_cnt_q <= 2'h0;
      end
      else
      begin
         if (push)
         begin
            fifo_q[fifo_wp_q] <= mem_q[rd_addr_q];
            fifo_wp_q         <= !fifo_wp_q;
         end
         if (pop)
            fifo_rp_q <= !fifo_rp_q;
         fifo_cnt_q <= fifo_cnt_q + 2'(push) - 2'(pop);
      end
   end

   // -----------------------------------------------------------------
   // Output shifter
   // -----------------------------------------------------------------
   logic [7:0] tx_q;
   logic       so_oe_q;
   logic [7:0] stat_byte;
   logic [7:0] load_byte;

   assign stat_o    = '{hw_protect_enable_bit: hpe_q, unused: 3'h0,
                        block_protect_high_bit: bp_q[1], block_protect_low_bit: bp_q[0],
                        write_enable_latch: wel_q, busy: busy_q};
   assign stat_byte = busy_q ? sep_pkg::STATUS_BUSY_ALL : 8'(stat_o);
   assign load_byte = (state_q == ST_RSTAT) ? stat_byte :
                      (out_valid ? fifo_q[fifo_rp_q] : sep_pkg::IDLE_BYTE);

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_q      <= 8'h00;
         so_oe_q   <= 1'b0;
         out_cnt_q <= 3'h0;
      end
      else if (!selected || !(state_q == ST_RDATA || state_q == ST_RSTAT))
      begin
         so_oe_q   <= 1'b0;
         out_cnt_q <= 3'h0;
      end
      else if (sck_fall)
      begin
         out_cnt_q <= out_cnt_q + 3'h1;
         so_oe_q   <= 1'b1;
         tx_q      <= (out_cnt_q == 3'h0) ? load_byte : {tx_q[6:0], 1'b0};
      end
   end

   assign so    = tx_q[7];
   assign so_oe = so_oe_q;

   // -----------------------------------------------------------------
   // Assertions
   // -----------------------------------------------------------------
   AST_PROT_ALL: assert property (@(posedge core_clk) disable iff (!rst_n)
      (commit_array && bp_q == 2'h3) |=>
         mem_q[{page_q, sep_pkg::PAGE_AW'(0)}] === $past(mem_q[{page_q, sep_pkg::PAGE_AW'(0)}]))
      else $error("whole-array level leaves an address writable");

   AST_HW_REJECT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (cs_rise && wstat_pend_q && hw_prot && !busy_q && !go_array) |=> !busy_q)
      else $error("status write started under hardware protection");

   AST_NEED_WEL: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(busy_q) |-> $past(wel_q))
      else $error("programming started with latch clear");

   AST_BUSY_IGNORE: assert property (@(posedge core_clk) disable iff (!rst_n)
      busy_q && $past(busy_q) |-> $stable(wel_q) && $stable(bp_q) && $stable(hpe_q))
      else $error("status cells changed while programming");

   AST_START_CS: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(busy_q) |-> $past(cs_rise))
      else $error("programming did not start at select rise");

   AST_BUSY_ALL_ONES: assert property (@(posedge core_clk) disable iff (!rst_n)
      (busy_q && so_oe_q && state_q == ST_RSTAT) |-> so)
      else $error("status not all ones while busy");

   AST_PAGE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      (byte_done && state_q == ST_WDATA) |=> $stable(page_q) && wlow_q == $past(wlow_q) + 1'b1)
      else $error("page address moved during page write");

   AST_WEL_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
      $fell(busy_q) |-> !wel_q)
      else $error("latch still set after programming");

   AST_READ_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (push && &rd_addr_q && !(byte_done && state_q == ST_ADDR_LO)) |=> rd_addr_q == '0)
      else $error("read address did not wrap to zero");

endmodule

// File: verif/sep_host_model.sv
// Host SPI mode 0 master model that drives the memory core's link.
module sep_host_model
(
   input  wire logic core_clk,
   input  wire logic so,
   input  wire logic so_oe,
   output logic      cs_n,
   output logic      sck,
   output logic      si
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      cs_n = 1'b1;
      sck  = 1'b0;
      si   = 1'b0;
   end

   // -------------------------------------------------------------
   // Link timing: 100 ns per sck phase, changed at falling edges.
   // -------------------------------------------------------------
   task automatic hw(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic sel();
      cs_n = 1'b0;
      hw(4);
   endtask

   task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--)
      begin
         si = tx[i];
         hw(4);
         sck   = 1'b1;
         // A released line reads as the inverse of its last level, so a lost enable shows.
         rx[i] = so_oe ? so : ~so;
         hw(4);
         sck = 1'b0;
      end
   endtask

   task automatic desel();
      hw(2);
      cs_n = 1'b1;
      // The idle input flips so a stale level never looks like data.
      si = ~si;
      hw(8);
   endtask
endmodule

// File: verif/sep_core_tb.sv
// Self-checking testbench of the serial memory command core.
module sep_core_tb;
   timeunit 1ns;
   timeprecision 100ps;

   logic                    core_clk;
   logic                    rst_n;
   logic                    wp_n;
   logic                    cs_n;
   logic                    sck;
   logic                    si;
   logic                    so;
   logic                    so_oe;
   sep_pkg::sep_status_type stat_o;
   int                      n_mismatch;
   int                      tests_run;
   logic [7:0]              rx[$];
   logic [7:0]              q[$];

   sep_core #(.ADDR_W(14), .WC_CYCLES(400)) u_sep_core
   (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cs_n     (cs_n),
      .sck      (sck),
      .si       (si),
      .wp_n     (wp_n),
      .so       (so),
      .so_oe    (so_oe),
      .stat_o   (stat_o)
   );

   sep_host_model u_sep_host_model
   (
      .core_clk (core_clk),
      .so       (so),
      .so_oe    (so_oe),
      .cs_n     (cs_n),
      .sck      (sck),
      .si       (si)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // -------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic frm(input logic [7:0] tx[$]);
      logic [7:0] r;
      rx = {};
      u_sep_host_model.sel();
      foreach (tx[i])
      begin
         u_sep_host_model.xb(tx[i], r);
         rx.push_back(r);
      end
      u_sep_host_model.desel();
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      frm({8'h03, a[15:8], a[7:0], 8'h06});
      chk(rx[3], exp);
   endtask

   // Polls status until ready; a bound that runs out ends the run.
   task automatic poll(input logic [7:0] exp);
      logic [7:0] r;
      u_sep_host_model.sel();
      u_sep_host_model.xb(8'h05, r);
      u_sep_host_model.xb(8'h00, r);
      chk(r, 8'hff);
      for (int k = 0; k < 30 && r[0] !== 1'b0; k++)
         u_sep_host_model.xb(8'h00, r);
      u_sep_host_model.desel();
      chk(r, exp);
      chk(stat_o, exp);
      if (r[0] !== 1'b0)
         give_verdict();
   endtask

   // Used where a commit may skip every byte; busy still lasts WC_CYCLES, and this waits up to 1000 cycles for it to clear.
   task automatic idle();
      for (int k = 0; k < 1000 && stat_o.busy !== 1'b0; k++)
         @(negedge core_clk);
      chk(8'(stat_o.busy), 8'h00);
      if (stat_o.busy !== 1'b0)
         give_verdict();
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task automatic t_reset();
      chk(stat_o, 8'h00);
      chk(8'(so_oe), 8'h00);
      frm({8'h05, 8'h00});
      chk(rx[1], 8'h00);
      $display("test reset done");
   endtask

   task automatic t_page();
      frm({8'h06});
      chk(stat_o, 8'h02);
      frm({8'h02, 8'h00, 8'h00, 8'h5a});
      frm({8'h04});
      chk(stat_o, 8'h03);
      poll(8'h00);
      frm({8'h06});
      q = {8'h02, 8'h3f, 8'hfe};
      for (int i = 0; i < 65; i++)
         q.push_back(8'(8'h10 + i));
      frm(q);
      poll(8'h00);
      frm({8'h03, 8'hff, 8'hfe, 8'h02, 8'h06, 8'h01});
      chk(rx[3], 8'h50);
      chk(rx[4], 8'h11);
      chk(rx[5], 8'h5a);
      rd(16'h3fc0, 8'h12);
      $display("test page done");
   endtask

   task automatic t_nowel();
      frm({8'h02, 8'h00, 8'h00, 8'h33});
      chk(stat_o, 8'h00);
      rd(16'h0000, 8'h5a);
      frm({8'h86});
      chk(stat_o, 8'h00);
      $display("test nowel done");
   endtask

   task automatic t_prot();
      frm({8'h06});
      frm({8'h01, 8'h8c});
      poll(8'h8c);
      wp_n = 1'b0;
      frm({8'h06});
      frm({8'h01, 8'h00});
      chk(stat_o & 8'hfd, 8'h8c);
      frm({8'h04});
      chk(stat_o, 8'h8c);
      frm({8'h06});
      frm({8'h02, 8'h00, 8'h00, 8'h77});
      idle();
      rd(16'h0000, 8'h5a);
      wp_n = 1'b1;
      frm({8'h06});
      frm({8'h01, 8'h04});
      poll(8'h04);
      frm({8'h06});
      frm({8'h02, 8'h2f, 8'hff, 8'h66});
      poll(8'h04);
      frm({8'h06});
      frm({8'h02, 8'h3f, 8'hff, 8'h99});
      idle();
      rd(16'h2fff, 8'h66);
      rd(16'h3fff, 8'h11);
      $display("test prot done");
   endtask

   initial
   begin
      rst_n      = 1'b0;
      wp_n       = 1'b1;
      n_mismatch = 0;
      tests_run  = 0;
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (4) @(negedge core_clk);
      t_reset();
      t_page();
      t_nowel();
      t_prot();
      give_verdict();
   end
endmodule
